// [src/cpu_decode_pkg.sv]
// constants, types and decode helpers for the operand addressing core
// assumes one clock (the E cycle) and memory that answers in the same cycle
package cpu_decode_pkg;

	// ----------------------------------------------------------------
	// reset values and flag layout
	// ----------------------------------------------------------------
	localparam logic [15:0] PC_RESET  = 16'h0000; // first fetch address
	localparam logic [15:0] SP_RESET  = 16'h00ff; // stack start
	localparam logic [7:0]  CCR_RESET = 8'hd0;    // mask set, top bits one
	localparam logic [1:0]  CCR_TOP   = 2'h3;     // unused bits read one
	localparam int C_BIT = 0; // carry/borrow
	localparam int V_BIT = 1; // overflow
	localparam int Z_BIT = 2; // zero
	localparam int N_BIT = 3; // negative
	localparam int I_BIT = 4; // interrupt mask
	localparam int H_BIT = 5; // half carry

	// ----------------------------------------------------------------
	// opcodes with special handling
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_TEST_A = 8'h4e; // counter test
	localparam logic [7:0] OP_TEST_B = 8'h5e; // counter test
	localparam logic [7:0] OP_BSR    = 8'h8d; // relative in imm column
	localparam logic [7:0] OP_INX    = 8'h08;
	localparam logic [7:0] OP_DEX    = 8'h09;
	localparam logic [7:0] OP_CLV    = 8'h0a;
	localparam logic [7:0] OP_SEV    = 8'h0b;
	localparam logic [7:0] OP_CLC    = 8'h0c;
	localparam logic [7:0] OP_SEC    = 8'h0d;
	localparam logic [7:0] OP_CLI    = 8'h0e;
	localparam logic [7:0] OP_SEI    = 8'h0f;
	localparam logic [7:0] OP_TAB    = 8'h16;
	localparam logic [7:0] OP_TBA    = 8'h17;
	localparam logic [7:0] OP_ABA    = 8'h1b;
	localparam logic [7:0] OP_INS    = 8'h31;
	localparam logic [7:0] OP_DES    = 8'h34;
	localparam logic [7:0] OP_ABX    = 8'h3a;
	localparam logic [7:0] OP_CLRA   = 8'h4f;
	localparam logic [7:0] OP_CLRB   = 8'h5f;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		register_only_mode, inline_operand_mode, page_zero_mode,
		pointer_offset_mode, absolute_long_mode, branch_offset_mode
	} mode_type;

	typedef enum logic [2:0] {DST_NONE, DST_A, DST_B, DST_D, DST_X, DST_S} dst_type;

	typedef struct packed {
		logic     valid; // assigned code
		logic     test;  // counter test code
		mode_type mode;  // addressing mode
		logic     wide;  // 16-bit operand
		dst_type  dst;   // load destination
	} decode_type;

	// classify from the first byte alone
	function automatic decode_type decode_op(input logic [7:0] op);
		decode_type d;
		logic [3:0] hi;
		logic [3:0] lo;
		d  = '0;
		hi = op[7:4];
		lo = op[3:0];
		d.test = (op == OP_TEST_A) || (op == OP_TEST_B);
		case (op)
			8'h00, 8'h02, 8'h03, 8'h12, 8'h13, 8'h14, 8'h15, 8'h18, 8'h1a,
			8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h41, 8'h42, 8'h45, 8'h4b, 8'h51,
			8'h52, 8'h55, 8'h5b, 8'h61, 8'h62, 8'h65, 8'h6b, 8'h71, 8'h72,
			8'h75, 8'h7b, 8'h87, 8'h8f, 8'hc7, 8'hcd, 8'hcf: d.valid = 1'b0;
			default: d.valid = !d.test;
		endcase
		case (hi)
			4'h2:                d.mode = branch_offset_mode;
			4'h6, 4'ha, 4'he:    d.mode = pointer_offset_mode;
			4'h7, 4'hb, 4'hf:    d.mode = absolute_long_mode;
			4'h9, 4'hd:          d.mode = page_zero_mode;
			4'h8, 4'hc:          d.mode = inline_operand_mode;
			default:             d.mode = register_only_mode;
		endcase
		if (op == OP_BSR)
			d.mode = branch_offset_mode;
		d.wide = hi[3] && (lo == 4'h3 || lo == 4'hc || lo == 4'he);
		if (hi[3] && lo == 4'h6)
			d.dst = hi[2] ? DST_B : DST_A;
		else if (hi[3] && hi[2] && lo == 4'hc)
			d.dst = DST_D;
		else if (hi[3] && lo == 4'he)
			d.dst = hi[2] ? DST_X : DST_S;
		if (!d.valid) begin
			d.mode = register_only_mode;
			d.dst  = DST_NONE;
			d.wide = 1'b0;
		end
		return d;
	endfunction

	// branch condition from the low opcode nibble and the flags
	function automatic logic branch_cond(input logic [3:0] c, input logic [7:0] f);
		logic nv;
		logic r;
		nv = f[N_BIT] ^ f[V_BIT];
		case (c[3:1])
			3'd0: r = 1'b1;
			3'd1: r = !(f[C_BIT] | f[Z_BIT]);
			3'd2: r = !f[C_BIT];
			3'd3: r = !f[Z_BIT];
			3'd4: r = !f[V_BIT];
			3'd5: r = !f[N_BIT];
			3'd6: r = !nv;
			default: r = !(f[Z_BIT] | nv);
		endcase
		return r ^ c[0];
	endfunction

endpackage

// [src/cpu_operand_addressing_decode.sv]
// operand addressing and decode core for an 8-bit processor
// assumes memory returns mem_rdata in the cycle that mem_addr is shown
//
// How it works
// RL1 - mode and operation known from opcode alone
// RL2 - 220 valid, 34 unassigned, 2 test codes
// RL3 - test codes count pc until reset
// RL4 - double accumulator is A high, B low
// RL5 - pc points at next instruction byte
// RL6 - stack pointer marks next free stack slot
// RL7 - index register holds data or base address
// RL8 - flags N Z V C, branches test them
// RL9 - half carry from bit 3
// RL10 - mask bit 4 blocks maskable interrupts
// RL11 - top two flag bits read one
// RL12 - inline operand follows opcode, 1 or 2 bytes
// RL13 - page zero: low byte given, high zero
// RL14 - two bytes form absolute address
// RL15 - unsigned offset plus index, index unchanged
// RL16 - register-only codes are one byte
// RL17 - taken branch adds signed displacement to pc
// RL18 - six memory modes, one E cycle per clock
// RL19 - address sums wrap at 16 bits
`timescale 1ns/1ps

module cpu_operand_addressing_decode
	import cpu_decode_pkg::*;
(
	input  wire logic        sys_clk,     // E cycle clock
	input  wire logic        rst,         // async reset
	input  wire logic        irq_n,       // maskable request pin
	input  wire logic [7:0]  mem_rdata,   // memory read data
	output logic      [15:0] mem_addr,    // bus address
	output logic             mem_rd,      // read strobe
	output logic      [15:0] prog_cnt,    // program counter
	output logic      [15:0] stack_ptr,   // stack pointer
	output logic      [15:0] index_reg,   // index register
	output logic      [15:0] acc_d,       // double accumulator
	output logic      [7:0]  ccr_view,    // flags as read
	output logic             irq_pending, // request not masked
	output decode_type       dec_info,    // last opcode decode
	output logic      [15:0] eff_addr,    // operand address
	output logic             ea_valid,    // eff_addr formed pulse
	output logic             bad_op       // unassigned code pulse
);

	// ----------------------------------------------------------------
	// state and internal registers
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_FETCH, ST_OPND1, ST_OPND2, ST_DATA1, ST_DATA2, ST_TEST
	} state_type;

	state_type   st;       // sequencer state
	logic [7:0]  acc_a;    // first accumulator
	logic [7:0]  acc_b;    // second accumulator
	logic [7:0]  hi_byte;  // held high byte
	logic [1:0]  irq_sync; // pin synchroniser
	logic [7:0]  opcode;   // opcode being executed
	decode_type  dec;      // decode of the byte on the bus
	logic [15:0] pc_inc;   // pc plus one
	logic [15:0] br_target;
	logic        br_take;
	logic [15:0] next_ea;  // address being formed
	logic        load_now; // final operand byte present
	logic [15:0] load_val; // value being loaded
	logic        is_inh;   // executable one-byte code this cycle
	logic [8:0]  aba_sum;
	logic [4:0]  aba_half;

	// ----------------------------------------------------------------
	// combinational helpers
	// ----------------------------------------------------------------
	assign dec       = decode_op(mem_rdata); // RL1
	assign pc_inc    = prog_cnt + 16'h0001;
	// displacement is counted from the byte after the instruction
	assign br_target = pc_inc + {{8{mem_rdata[7]}}, mem_rdata}; // RL17 RL19
	// the subroutine branch is always taken, other branches test the flags
	assign br_take   = (opcode == OP_BSR) || branch_cond(opcode[3:0], ccr_view); // RL8 RL17
	assign is_inh    = st == ST_FETCH && dec.valid &&
		dec.mode == register_only_mode; // RL16
	assign aba_sum   = {1'b0, acc_a} + {1'b0, acc_b};
	assign aba_half  = {1'b0, acc_a[3:0]} + {1'b0, acc_b[3:0]};
	assign load_val  = dec_info.wide ? {hi_byte, mem_rdata} : {8'h00, mem_rdata};

	// operand address for the current operand byte
	always_comb begin
		case (dec_info.mode)
			page_zero_mode:      next_ea = {8'h00, mem_rdata};             // RL13
			pointer_offset_mode: next_ea = index_reg + {8'h00, mem_rdata}; // RL15 RL19
			default:             next_ea = {hi_byte, mem_rdata};           // RL14
		endcase
	end

	// last byte of a load is on the bus
	always_comb begin
		load_now = 1'b0;
		case (st)
			ST_OPND1: load_now = dec_info.mode == inline_operand_mode && !dec_info.wide;
			ST_OPND2: load_now = dec_info.mode == inline_operand_mode; // RL12
			ST_DATA1: load_now = !dec_info.wide;
			ST_DATA2: load_now = 1'b1;
			default:  load_now = 1'b0;
		endcase
		load_now = load_now && dec_info.dst != DST_NONE;
	end

	// ----------------------------------------------------------------
	// sequencer and bus address
	// ----------------------------------------------------------------
	// every state issues one read; the next address is chosen here
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st       <= ST_FETCH;
			mem_addr <= PC_RESET;
			mem_rd   <= 1'b0;
		end else begin
			mem_rd   <= 1'b1; // RL18
			mem_addr <= pc_inc;
			case (st)
				ST_FETCH: begin
					if (dec.test)
						st <= ST_TEST; // RL3
					else if (dec.mode == register_only_mode)
						st <= ST_FETCH; // RL16
					else
						st <= ST_OPND1;
				end
				ST_OPND1: begin
					case (dec_info.mode)
						inline_operand_mode: st <= dec_info.wide ? ST_OPND2 : ST_FETCH;
						absolute_long_mode:  st <= ST_OPND2;
						branch_offset_mode: begin
							st <= ST_FETCH;
							if (br_take)
								mem_addr <= br_target; // RL17
						end
						default: begin
							st <= dec_info.dst != DST_NONE ? ST_DATA1 : ST_FETCH;
							if (dec_info.dst != DST_NONE)
								mem_addr <= next_ea;
						end
					endcase
				end
				ST_OPND2: begin
					st <= ST_FETCH;
					if (dec_info.mode == absolute_long_mode && dec_info.dst != DST_NONE) begin
						st       <= ST_DATA1;
						mem_addr <= next_ea; // RL14
					end
				end
				ST_DATA1: begin
					st       <= dec_info.wide ? ST_DATA2 : ST_FETCH;
					mem_addr <= dec_info.wide ? eff_addr + 16'h0001 : prog_cnt;
				end
				ST_DATA2: begin
					st       <= ST_FETCH;
					mem_addr <= prog_cnt;
				end
				default: st <= ST_TEST; // RL3 only reset leaves
			endcase
		end
	end

	// ----------------------------------------------------------------
	// program counter
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			prog_cnt <= PC_RESET;
		else if (st == ST_OPND1 && dec_info.mode == branch_offset_mode && br_take)
			prog_cnt <= br_target; // RL17
		else if (st == ST_FETCH || st == ST_OPND1 || st == ST_OPND2 || st == ST_TEST)
			prog_cnt <= pc_inc; // RL5 RL3 RL19
	end

	// ----------------------------------------------------------------
	// decode capture, operand address and held byte
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			opcode   <= 8'h01;
			dec_info <= '0;
			hi_byte  <= 8'h00;
			eff_addr <= 16'h0000;
			ea_valid <= 1'b0;
			bad_op   <= 1'b0;
		end else begin
			ea_valid <= 1'b0;
			bad_op   <= 1'b0;
			if (st == ST_FETCH) begin
				opcode   <= mem_rdata;
				dec_info <= dec;                    // RL1
				bad_op   <= !dec.valid && !dec.test; // RL2
			end
			if (st == ST_OPND1 || st == ST_DATA1)
				hi_byte <= mem_rdata;
			if ((st == ST_OPND1 && (dec_info.mode == page_zero_mode ||
				dec_info.mode == pointer_offset_mode)) ||
				(st == ST_OPND2 && dec_info.mode == absolute_long_mode)) begin
				eff_addr <= next_ea; // RL13 RL14 RL15
				ea_valid <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// accumulators
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			acc_a <= 8'h00;
			acc_b <= 8'h00;
		end else if (load_now) begin
			case (dec_info.dst)
				DST_A: acc_a <= mem_rdata;
				DST_B: acc_b <= mem_rdata;
				DST_D: {acc_a, acc_b} <= load_val; // RL4
				default: ;
			endcase
		end else if (is_inh) begin
			case (mem_rdata)
				OP_ABA:  acc_a <= aba_sum[7:0];
				OP_TAB:  acc_b <= acc_a;
				OP_TBA:  acc_a <= acc_b;
				OP_CLRA: acc_a <= 8'h00;
				OP_CLRB: acc_b <= 8'h00;
				default: ;
			endcase
		end
	end

	// double accumulator view
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			acc_d <= 16'h0000;
		else
			acc_d <= {acc_a, acc_b}; // RL4
	end

	// ----------------------------------------------------------------
	// index register and stack pointer
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			index_reg <= 16'h0000;
			stack_ptr <= SP_RESET;
		end else if (load_now) begin
			if (dec_info.dst == DST_X)
				index_reg <= load_val; // RL7
			if (dec_info.dst == DST_S)
				stack_ptr <= load_val; // RL6
		end else if (is_inh) begin
			case (mem_rdata)
				OP_INX: index_reg <= index_reg + 16'h0001;
				OP_DEX: index_reg <= index_reg - 16'h0001;
				OP_ABX: index_reg <= index_reg + {8'h00, acc_b};
				OP_INS: stack_ptr <= stack_ptr + 16'h0001; // RL6
				OP_DES: stack_ptr <= stack_ptr - 16'h0001; // RL6
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// condition codes
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ccr_view <= CCR_RESET;
		end else begin
			ccr_view[7:6] <= CCR_TOP; // RL11
			if (load_now) begin
				ccr_view[N_BIT] <= dec_info.wide ? load_val[15] : mem_rdata[7]; // RL8
				ccr_view[Z_BIT] <= dec_info.wide ? load_val == 16'h0000 :
					mem_rdata == 8'h00;
				ccr_view[V_BIT] <= 1'b0;
			end else if (is_inh) begin
				case (mem_rdata)
					OP_CLC: ccr_view[C_BIT] <= 1'b0;
					OP_SEC: ccr_view[C_BIT] <= 1'b1;
					OP_CLV: ccr_view[V_BIT] <= 1'b0;
					OP_SEV: ccr_view[V_BIT] <= 1'b1;
					OP_CLI: ccr_view[I_BIT] <= 1'b0; // RL10
					OP_SEI: ccr_view[I_BIT] <= 1'b1; // RL10
					OP_INX, OP_DEX: ccr_view[Z_BIT] <=
						(mem_rdata == OP_INX ? index_reg + 16'h0001 :
						index_reg - 16'h0001) == 16'h0000;
					OP_ABA: begin
						ccr_view[H_BIT] <= aba_half[4]; // RL9
						ccr_view[C_BIT] <= aba_sum[8];  // RL8
						ccr_view[N_BIT] <= aba_sum[7];
						ccr_view[Z_BIT] <= aba_sum[7:0] == 8'h00;
						ccr_view[V_BIT] <= (acc_a[7] == acc_b[7]) &&
							(aba_sum[7] != acc_a[7]);
					end
					default: ;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// maskable request: two-flop synchroniser, then the mask
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irq_sync    <= 2'h3;
			irq_pending <= 1'b0;
		end else begin
			irq_sync    <= {irq_sync[0], irq_n};
			irq_pending <= !irq_sync[1] && !ccr_view[I_BIT]; // RL10
		end
	end

endmodule

// [verif/cpu_mem_model.sv]
// program and data memory standing on the processor bus
// assumes the core samples read data at the rising edge that ends each address cycle
`timescale 1ns/1ps

module cpu_mem_model (
	input  wire logic [15:0] mem_addr, // bus address from the core
	output logic      [7:0]  mem_rdata // byte at that address
);
	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [7:0] mem [0:65535]; // loaded by the bench while the core is in reset

	// answers at once, with no wait states
	assign mem_rdata = mem[mem_addr];
endmodule

// [verif/cpu_operand_addressing_decode_asserts.sv]
// timing checks on the ports of the operand addressing core
// assumes one clock and an active-high asynchronous reset
`timescale 1ns/1ps

module cpu_operand_addressing_decode_asserts
	import cpu_decode_pkg::*;
(
	input wire logic        sys_clk,     // core clock
	input wire logic        rst,         // core reset
	input wire logic        irq_n,       // request pin
	input wire logic [7:0]  mem_rdata,   // memory data
	input wire logic [15:0] mem_addr,    // bus address
	input wire logic        mem_rd,      // read strobe
	input wire logic [15:0] prog_cnt,    // program counter
	input wire logic [15:0] stack_ptr,   // stack pointer
	input wire logic [15:0] index_reg,   // index register
	input wire logic [15:0] acc_d,       // double accumulator
	input wire logic [7:0]  ccr_view,    // flags
	input wire logic        irq_pending, // unmasked request
	input wire decode_type  dec_info,    // opcode decode
	input wire logic [15:0] eff_addr,    // operand address
	input wire logic        ea_valid,    // address formed
	input wire logic        bad_op       // unassigned code
);
	// ----------------------------------------------------------------
	// sequences and properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence test_run;
		dec_info.test [*3];
	endsequence

	sequence idle_pin;
		irq_n [*4];
	endsequence

	a_test_counts: assert property (test_run |=> mem_addr == $past(mem_addr) + 16'h0001)
		else $error("address does not count in test mode");
	a_ccr_top: assert property (ccr_view[7:6] == CCR_TOP)
		else $error("unused flag bits not one");
	a_mask_blocks: assert property (ccr_view[I_BIT] && $past(ccr_view[I_BIT]) |-> !irq_pending)
		else $error("request pending while masked");
	a_idle_pin: assert property (idle_pin |-> !irq_pending)
		else $error("request pending with pin idle");
	a_ea_pulse: assert property (ea_valid |=> !ea_valid)
		else $error("operand address pulse too long");
	a_bad_code: assert property (bad_op |-> !dec_info.valid && !dec_info.test)
		else $error("bad code flag on assigned code");
	a_no_ea_inherent: assert property (ea_valid |-> dec_info.mode != register_only_mode)
		else $error("operand address in register-only mode");
	a_ext_addr: assert property (ea_valid && dec_info.mode == absolute_long_mode
		|-> eff_addr == {$past(mem_rdata, 2), $past(mem_rdata, 1)})
		else $error("absolute address not from two bytes");
	a_page_zero: assert property (ea_valid && dec_info.mode == page_zero_mode
		|-> eff_addr == {8'h00, $past(mem_rdata, 1)})
		else $error("page zero address wrong");
	a_index_sum: assert property (ea_valid && dec_info.mode == pointer_offset_mode
		|-> eff_addr == index_reg + {8'h00, $past(mem_rdata, 1)})
		else $error("indexed address wrong");
endmodule

bind cpu_operand_addressing_decode cpu_operand_addressing_decode_asserts i_chk (
	.sys_clk(sys_clk), .rst(rst), .irq_n(irq_n), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
	.mem_rd(mem_rd), .prog_cnt(prog_cnt), .stack_ptr(stack_ptr), .index_reg(index_reg),
	.acc_d(acc_d), .ccr_view(ccr_view), .irq_pending(irq_pending), .dec_info(dec_info),
	.eff_addr(eff_addr), .ea_valid(ea_valid), .bad_op(bad_op)
);

// [verif/cpu_operand_addressing_decode_tb.sv]
// self-checking bench for the operand addressing core
// assumes a zero-wait memory model; each scenario reloads memory under reset
`timescale 1ns/1ps

module cpu_operand_addressing_decode_tb;
	import cpu_decode_pkg::*;

	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic        sys_clk;     // 50 MHz clock
	logic        rst;         // reset
	logic        irq_n;       // request pin
	logic [7:0]  mem_rdata;   // memory data
	logic [15:0] mem_addr;    // bus address
	logic        mem_rd;      // read strobe
	logic [15:0] prog_cnt;    // program counter
	logic [15:0] stack_ptr;   // stack pointer
	logic [15:0] index_reg;   // index register
	logic [15:0] acc_d;       // double accumulator
	logic [7:0]  ccr_view;    // flags
	logic        irq_pending; // unmasked request
	decode_type  dec_info;    // opcode decode
	logic [15:0] eff_addr;    // operand address
	logic        ea_valid;    // address pulse
	logic        bad_op;      // bad code pulse
	int          n_mismatch;  // mismatches
	int          cmp_count;   // comparisons
	logic        found;       // wait result

	// clock
	always #10 sys_clk = ~sys_clk;

	cpu_operand_addressing_decode i_cpu_operand_addressing_decode (
		.sys_clk(sys_clk), .rst(rst), .irq_n(irq_n), .mem_rdata(mem_rdata),
		.mem_addr(mem_addr), .mem_rd(mem_rd), .prog_cnt(prog_cnt), .stack_ptr(stack_ptr),
		.index_reg(index_reg), .acc_d(acc_d), .ccr_view(ccr_view),
		.irq_pending(irq_pending), .dec_info(dec_info), .eff_addr(eff_addr),
		.ea_valid(ea_valid), .bad_op(bad_op)
	);

	cpu_mem_model i_cpu_mem_model (.mem_addr(mem_addr), .mem_rdata(mem_rdata));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task check(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task tick;
		@(posedge sys_clk);
		#1;
	endtask

	// hold reset and fill memory with the counter test code
	task begin_prog;
		@(negedge sys_clk);
		rst = 1'b1;
		for (int i = 0; i < 65536; i++) i_cpu_mem_model.mem[i] = OP_TEST_A;
	endtask

	// n bytes of v, first byte in the top lane
	task prog(input logic [15:0] a, input int n, input logic [63:0] v);
		for (int i = 0; i < n; i++) i_cpu_mem_model.mem[a + i[15:0]] = v[8*(n-1-i) +: 8];
	endtask

	task go;
		repeat (10) @(negedge sys_clk);
		rst = 1'b0;
	endtask

	task wait_addr(input logic [15:0] a, input int bound);
		found = 1'b0;
		for (int i = 0; i < bound && !found; i++) begin
			tick();
			if (mem_addr === a) found = 1'b1;
		end
		check("address reached", 16'h0001, {15'h0, found});
	endtask

	task wait_ea(input logic [15:0] a, input mode_type m);
		found = 1'b0;
		for (int i = 0; i < 20 && !found; i++) begin
			tick();
			if (ea_valid === 1'b1) found = 1'b1;
		end
		check("ea_valid", 16'h0001, {15'h0, found});
		check("eff_addr", a, eff_addr);
		check("mode", {13'h0, m}, {13'h0, dec_info.mode});
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task s_reset;
		begin_prog();
		irq_n = 1'b0;
		repeat (3) tick();
		check("prog_cnt", PC_RESET, prog_cnt);
		check("stack_ptr", SP_RESET, stack_ptr);
		check("ccr_view", {8'h00, CCR_RESET}, {8'h00, ccr_view});
		check("irq_pending", 16'h0000, {15'h0, irq_pending});
		check("mem_rd", 16'h0000, {15'h0, mem_rd});
		@(negedge sys_clk);
		irq_n = 1'b1;
		go();
	endtask

	task s_modes;
		logic [15:0] a;
		begin_prog();
		prog(16'h0000, 3, 64'hce1234); // load index inline
		prog(16'h0003, 2, 64'ha610);
		prog(16'h0005, 2, 64'h963c);
		prog(16'h0007, 3, 64'hfc8000);
		prog(16'h000a, 2, 64'hc699);
		prog(16'h8000, 2, 64'hc37e);
		go();
		wait_ea(16'h1244, pointer_offset_mode);
		wait_ea(16'h003c, page_zero_mode);
		wait_ea(16'h8000, absolute_long_mode);
		wait_addr(16'h000c, 16);
		repeat (2) tick();
		check("index_reg", 16'h1234, index_reg);
		check("acc_d", 16'hc399, acc_d);
		a = mem_addr;
		repeat (5) tick();
		check("counting", a + 16'h0005, mem_addr);
	endtask

	task s_wrap;
		begin_prog();
		prog(16'h0000, 5, 64'hcefff0a620);
		go();
		wait_ea(16'h0010, pointer_offset_mode);
	endtask

	task s_branch;
		logic [31:0] cases [5];
		cases = '{32'h2040_0042, 32'h2080_ff82, 32'h0c25_0003, 32'h0d25_0013,
			32'h8d10_0012};
		for (int i = 0; i < 5; i++) begin
			begin_prog();
			if (i < 2 || i == 4) prog(16'h0000, 2, {48'h0, cases[i][31:16]});
			else prog(16'h0000, 3, {40'h0, cases[i][31:16], 8'h10});
			go();
			wait_addr(cases[i][15:0], 12);
			if (i == 3) check("carry", 16'h0001, {15'h0, ccr_view[C_BIT]});
		end
	endtask

	// inline loads, add with half carry, stack step, copy a to b
	task s_alu;
		begin_prog();
		prog(16'h0000, 7, 64'h8608c6081b3116);
		go();
		wait_addr(16'h0008, 12);
		check("acc_d", 16'h1010, acc_d);
		check("half carry", 16'h0001, {15'h0, ccr_view[H_BIT]});
		check("carry", 16'h0000, {15'h0, ccr_view[C_BIT]});
		check("stack_ptr", SP_RESET + 16'h0001, stack_ptr);
		check("mem_rd", 16'h0001, {15'h0, mem_rd});
	endtask

	task s_bad;
		begin_prog();
		prog(16'h0000, 1, 64'h00);
		go();
		found = 1'b0;
		for (int i = 0; i < 8; i++) begin
			tick();
			if (bad_op === 1'b1) found = ~found;
		end
		check("bad_op once", 16'h0001, {15'h0, found});
		check("test decode", 16'h0001, {15'h0, dec_info.test});
	endtask

	task s_irq;
		begin_prog();
		irq_n = 1'b0;
		prog(16'h0000, 5, 64'h010101010e); // idle codes while masked, then unmask
		go();
		repeat (4) tick();
		check("masked", 16'h0000, {15'h0, irq_pending});
		found = 1'b0;
		for (int i = 0; i < 12 && !found; i++) begin
			tick();
			if (irq_pending === 1'b1) found = 1'b1;
		end
		check("unmasked", 16'h0001, {15'h0, found});
		check("mask bit", 16'h0000, {15'h0, ccr_view[I_BIT]});
	endtask

	// ----------------------------------------------------------------
	// run control
	// ----------------------------------------------------------------
	task wrap_up;
		if (n_mismatch == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// watchdog well beyond the few hundred cycles the scenarios need
	initial begin
		#400000;
		n_mismatch++;
		wrap_up();
	end

	// main sequence
	initial begin
		sys_clk = 1'b0;
		rst = 1'b1;
		irq_n = 1'b1;
		n_mismatch = 0;
		cmp_count = 0;
		s_reset();
		s_modes();
		s_wrap();
		s_branch();
		s_alu();
		s_bad();
		s_irq();
		wrap_up();
	end
endmodule
